// file: hdl/pbr_bridge.sv
// Summary of operation
// R1: Two 32-bit PCI phases per local QWORD
// R2: Hold QWORD, steer half; strobes name half
// R3: Aligned start takes low half first
// R4: Local master gives request with address, command, length
// R5: Raise PCI request the clock after request
// R6: Grant locally when gntn low, bus idle
// R7: Request and grant seen: address loading, capture
// R8: Local master drops request after address loading
// R9: Drive frame, req64, address, command; bus transaction
// R10: Load burst counter in address phase
// R11: Local master gives byte enables; ready when able
// R12: Drop reqn after frame with request gone
// R13: Turnaround floats ad, drives enables, irdyn from ready
// R14: Local grant follows gntn deassertion
// R15: No ack64n: clear wide flag, counter two
// R16: Frame held while phases remain; irdyn&trdyn completes
// R17: First word to low half, counter to one
// R18: Low strobe after trdyn and ready both asserted
// R19: Irdyn follows local ready of previous cycle
// R20: Final phase: frame released, irdyn kept
// R21: Second word to high half, counter to zero
// R22: After last phase release bus, report normal termination
// R23: Fixed distinct status codes, stable each clock
`timescale 1ns/1ps

module pbr_bridge (
	// Clock and reset
	input  wire logic                        core_clk,
	input  wire logic                        rst,
	// Local side
	pbr_local_if.bridge                      lb,
	// PCI arbitration
	output      logic                        reqn,
	input  wire logic                        gntn,
	// PCI two-way control pins
	input  wire logic                        framen_in,
	output      logic                        framen_out,
	output      logic                        framen_oe,
	input  wire logic                        irdyn_in,
	output      logic                        irdyn_out,
	output      logic                        irdyn_oe,
	output      logic                        req64n_out,
	output      logic                        req64n_oe,
	// PCI address/data and command
	input  wire logic [pbr_pkg::HALF_W-1:0]  ad_in,
	output      logic [pbr_pkg::HALF_W-1:0]  ad_out,
	output      logic                        ad_oe,
	output      logic [pbr_pkg::CMD_W-1:0]   cben_out,
	output      logic                        cben_oe,
	// PCI target response
	input  wire logic                        trdyn,
	input  wire logic                        devseln,
	input  wire logic                        ack64n
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		S_IDLE, S_REQ, S_GRANT, S_LOAD, S_ADDR, S_TURN, S_DATA, S_TERM
	} pbr_state_t;

	pbr_state_t                       state_ff;
	logic                             reqn_ff;
	logic                             lgnt_n_ff;
	logic [pbr_pkg::STAT_W-1:0]       status_ff;
	logic [pbr_pkg::END_W-1:0]        end_ff;
	logic [pbr_pkg::HALF_W-1:0]       addr_ff;
	logic [pbr_pkg::CMD_W-1:0]        cmd_ff;
	logic [pbr_pkg::BURST_W-1:0]      burst_ff;
	logic [pbr_pkg::BURST_W-1:0]      beats_ff;
	logic [pbr_pkg::BE_W-1:0]         be_ff;
	logic                             half_ff;
	logic                             wide_n_ff;
	logic                             framen_ff;
	logic                             framen_oe_ff;
	logic                             irdyn_ff;
	logic                             irdyn_oe_ff;
	logic                             req64n_ff;
	logic                             ad_oe_ff;
	logic                             cben_oe_ff;
	logic [pbr_pkg::CMD_W-1:0]        cben_ff;
	logic [pbr_pkg::DATA_W-1:0]       data_ff;
	logic                             lo_stb_n_ff;
	logic                             hi_stb_n_ff;

	logic                             in_data;
	logic                             phase_done;
	logic                             split_now;
	logic [pbr_pkg::BURST_W-1:0]      nxt_beats;
	logic                             nxt_irdyn;

	// Picks the byte enables of one DWORD half
	function automatic logic [pbr_pkg::CMD_W-1:0] half_be(
		input logic [pbr_pkg::BE_W-1:0] be,
		input logic                     upper
	);
		half_be = upper ? be[7:4] : be[3:0];
	endfunction

	assign in_data    = (state_ff == S_TURN) || (state_ff == S_DATA);
	assign phase_done = in_data && !irdyn_ff && !trdyn;                    // [R16]
	assign split_now  = in_data && !wide_n_ff && !devseln && ack64n;

	always_comb begin
		nxt_beats = beats_ff;
		if (split_now) begin
			nxt_beats = phase_done ? pbr_pkg::BEATS_ONE : pbr_pkg::BEATS_SPLIT;
		end else if (phase_done && beats_ff != pbr_pkg::BEATS_ZERO) begin
			nxt_beats = beats_ff - pbr_pkg::BEATS_ONE;
		end
		// Once frame is released irdyn must stay until the last phase ends
		if (framen_ff && !irdyn_ff) begin
			nxt_irdyn = 1'b0;                                              // [R20]
		end else begin
			nxt_irdyn = lb.local_ready_n;                                  // [R19]
		end
	end

	// ----------------------------------------------------------------
	// Sequencer and local status
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_ff  <= S_IDLE;
			status_ff <= pbr_pkg::ST_IDLE;
		end else begin
			case (state_ff)
				S_IDLE: begin
					if (!lb.local_wide_request_n) begin
						state_ff <= S_REQ;
					end
				end
				S_REQ: begin
					if (lb.local_wide_request_n) begin
						state_ff <= S_IDLE;
					end else if (!gntn && framen_in && irdyn_in) begin
						state_ff <= S_GRANT;
					end
				end
				S_GRANT: begin
					if (!lb.local_wide_request_n && !lgnt_n_ff) begin
						state_ff  <= S_LOAD;
						status_ff <= pbr_pkg::ST_ADDR_LOAD;           // [R7] [R23]
					end else if (lb.local_wide_request_n) begin
						state_ff <= S_IDLE;
					end else if (lgnt_n_ff) begin
						state_ff <= S_REQ;
					end
				end
				S_LOAD: begin
					if (!gntn) begin
						state_ff  <= S_ADDR;
						status_ff <= pbr_pkg::ST_BUS_TRANS;           // [R9] [R23]
					end else begin
						state_ff  <= S_REQ;
						status_ff <= pbr_pkg::ST_IDLE;
					end
				end
				S_ADDR: begin
					state_ff <= S_TURN;
				end
				S_TURN, S_DATA: begin
					if (phase_done && framen_ff) begin
						state_ff  <= S_TERM;
						status_ff <= pbr_pkg::ST_BUS_TERM;            // [R22] [R23]
					end else begin
						state_ff <= S_DATA;
					end
				end
				S_TERM: begin
					state_ff  <= S_IDLE;
					status_ff <= pbr_pkg::ST_IDLE;
				end
				default: begin
					state_ff  <= S_IDLE;
					status_ff <= pbr_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Arbitration: PCI request and local grant
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			reqn_ff <= 1'b1;
		end else if (state_ff == S_IDLE && !lb.local_wide_request_n) begin
			reqn_ff <= 1'b0;                                               // [R5]
		end else if (!framen_ff && framen_oe_ff && lb.local_wide_request_n) begin
			reqn_ff <= 1'b1;                                               // [R12]
		end else if (state_ff == S_REQ && lb.local_wide_request_n) begin
			reqn_ff <= 1'b1;
		end else if (state_ff == S_TERM) begin
			reqn_ff <= 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			lgnt_n_ff <= 1'b1;
		end else if (state_ff == S_REQ) begin
			lgnt_n_ff <= !(!gntn && framen_in && irdyn_in);                // [R6]
		end else if (!lgnt_n_ff) begin
			lgnt_n_ff <= gntn;                                             // [R14]
		end
	end

	// ----------------------------------------------------------------
	// Captured request and burst counter
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			addr_ff  <= pbr_pkg::ADDR_RST;
			cmd_ff   <= pbr_pkg::CMD_RST;
			burst_ff <= pbr_pkg::BEATS_ZERO;
		end else if (state_ff == S_GRANT && !lb.local_wide_request_n && !lgnt_n_ff) begin
			addr_ff  <= lb.local_start_addr;                               // [R7]
			cmd_ff   <= lb.local_cmd;
			burst_ff <= lb.local_burst_size;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			beats_ff  <= pbr_pkg::BEATS_ZERO;
			wide_n_ff <= 1'b1;
		end else if (state_ff == S_LOAD && !gntn) begin
			beats_ff  <= burst_ff;                                         // [R10]
			wide_n_ff <= 1'b0;
		end else begin
			beats_ff <= nxt_beats;                                         // [R17] [R21]
			if (split_now) begin
				wide_n_ff <= 1'b1;                                         // [R15]
			end
		end
	end

	// ----------------------------------------------------------------
	// PCI pin drivers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			framen_ff    <= 1'b1;
			framen_oe_ff <= 1'b0;
			req64n_ff    <= 1'b1;
			ad_oe_ff     <= 1'b0;
		end else if (state_ff == S_LOAD && !gntn) begin
			framen_ff    <= 1'b0;                                          // [R9]
			framen_oe_ff <= 1'b1;
			req64n_ff    <= 1'b0;
			ad_oe_ff     <= 1'b1;
		end else if (state_ff == S_ADDR) begin
			ad_oe_ff <= 1'b0;                                              // [R13]
		end else if (in_data && phase_done && framen_ff) begin
			framen_oe_ff <= 1'b0;                                          // [R22]
			req64n_ff    <= 1'b1;
		end else if (state_ff == S_DATA && nxt_beats == pbr_pkg::BEATS_ONE && !nxt_irdyn) begin
			framen_ff <= 1'b1;                                             // [R16] [R20]
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			irdyn_ff    <= 1'b1;
			irdyn_oe_ff <= 1'b0;
		end else if (state_ff == S_ADDR) begin
			irdyn_ff    <= lb.local_ready_n;                               // [R13]
			irdyn_oe_ff <= 1'b1;
		end else if (in_data && phase_done && framen_ff) begin
			irdyn_ff <= 1'b1;                                              // [R22]
		end else if (in_data) begin
			irdyn_ff <= nxt_irdyn;                                         // [R19]
		end else if (state_ff == S_TERM) begin
			irdyn_oe_ff <= 1'b0;
		end
	end

	// Enables of the current half go out; the next half follows each phase
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cben_ff    <= pbr_pkg::CMD_RST;
			cben_oe_ff <= 1'b0;
			be_ff      <= pbr_pkg::BE_RST;
			half_ff    <= 1'b0;
		end else if (state_ff == S_LOAD && !gntn) begin
			cben_ff    <= cmd_ff;                                          // [R9]
			cben_oe_ff <= 1'b1;
			half_ff    <= addr_ff[pbr_pkg::QW_ADDR_BIT];                   // [R3]
		end else if (state_ff == S_ADDR) begin
			be_ff   <= lb.local_cmd_byte_enable_input;
			cben_ff <= half_be(lb.local_cmd_byte_enable_input, half_ff);   // [R13]
		end else if (in_data && phase_done && framen_ff) begin
			cben_oe_ff <= 1'b0;                                            // [R22]
		end else if (phase_done) begin
			half_ff <= !half_ff;                                           // [R1]
			cben_ff <= half_be(be_ff, !half_ff);
		end
	end

	// ----------------------------------------------------------------
	// Local read data and half strobes
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			data_ff     <= pbr_pkg::DATA_RST;
			lo_stb_n_ff <= 1'b1;
			hi_stb_n_ff <= 1'b1;
		end else begin
			lo_stb_n_ff <= 1'b1;
			hi_stb_n_ff <= 1'b1;
			if (phase_done && !half_ff) begin
				data_ff[31:0] <= ad_in;                                    // [R2] [R17]
				lo_stb_n_ff   <= lb.local_ready_n;                         // [R18]
			end else if (phase_done) begin
				data_ff[63:32] <= ad_in;                                   // [R21]
				hi_stb_n_ff    <= lb.local_ready_n;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			end_ff <= pbr_pkg::END_NONE;
		end else if (state_ff == S_TURN || state_ff == S_DATA) begin
			if (phase_done && framen_ff) begin
				end_ff <= pbr_pkg::END_NORMAL;                             // [R22]
			end
		end else if (state_ff == S_LOAD) begin
			end_ff <= pbr_pkg::END_NONE;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign reqn                     = reqn_ff;
	assign framen_out               = framen_ff;
	assign framen_oe                = framen_oe_ff;
	assign irdyn_out                = irdyn_ff;
	assign irdyn_oe                 = irdyn_oe_ff;
	assign req64n_out               = req64n_ff;
	assign req64n_oe                = framen_oe_ff;
	assign ad_out                   = addr_ff;
	assign ad_oe                    = ad_oe_ff;
	assign cben_out                 = cben_ff;
	assign cben_oe                  = cben_oe_ff;
	assign lb.local_grant_n         = lgnt_n_ff;
	assign lb.local_transfer_state  = status_ff;
	assign lb.local_end_reason      = end_ff;
	assign lb.local_beats_remaining = beats_ff;
	assign lb.wide_transfer_flag_n  = wide_n_ff;
	assign lb.low_half_strobe_n     = lo_stb_n_ff;
	assign lb.high_half_strobe_n    = hi_stb_n_ff;
	assign lb.local_data_out        = data_ff;

endmodule

// file: hdl/pbr_pkg.sv
package pbr_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int DATA_W  = 64;
	localparam int HALF_W  = 32;
	localparam int BE_W    = 8;
	localparam int CMD_W   = 4;
	localparam int BURST_W = 8;
	localparam int STAT_W  = 4;
	localparam int END_W   = 2;
	localparam int FIFO_DEPTH = 2;

	// ----------------------------------------------------------------
	// Local status codes and end reasons
	// ----------------------------------------------------------------
	localparam logic [STAT_W-1:0] ST_IDLE      = 4'h0;
	localparam logic [STAT_W-1:0] ST_ADDR_LOAD = 4'h1;
	localparam logic [STAT_W-1:0] ST_BUS_TRANS = 4'h2;
	localparam logic [STAT_W-1:0] ST_BUS_TERM  = 4'h3;

	localparam logic [END_W-1:0] END_NONE   = 2'h0;
	localparam logic [END_W-1:0] END_NORMAL = 2'h1;

	// ----------------------------------------------------------------
	// Counts, field positions and reset values
	// ----------------------------------------------------------------
	localparam logic [BURST_W-1:0] BEATS_SPLIT = 8'h02;
	localparam logic [BURST_W-1:0] BEATS_ONE   = 8'h01;
	localparam logic [BURST_W-1:0] BEATS_ZERO  = 8'h00;
	localparam int                 QW_ADDR_BIT = 2;
	localparam logic [HALF_W-1:0]  DWORD_STEP  = 32'h0000_0004;
	localparam logic [HALF_W-1:0]  ADDR_RST    = 32'h0000_0000;
	localparam logic [DATA_W-1:0]  DATA_RST    = 64'h0000_0000_0000_0000;
	localparam logic [BE_W-1:0]    BE_RST      = 8'hff;
	localparam logic [CMD_W-1:0]   CMD_RST     = 4'h0;

endpackage

// file: hdl/pbr_local_if.sv
`timescale 1ns/1ps

interface pbr_local_if;
	logic                               local_wide_request_n;
	logic [pbr_pkg::HALF_W-1:0]         local_start_addr;
	logic [pbr_pkg::BE_W-1:0]           local_cmd_byte_enable_input;
	logic [pbr_pkg::CMD_W-1:0]          local_cmd;
	logic [pbr_pkg::BURST_W-1:0]        local_burst_size;
	logic                               local_ready_n;
	logic                               local_grant_n;
	logic [pbr_pkg::STAT_W-1:0]         local_transfer_state;
	logic [pbr_pkg::END_W-1:0]          local_end_reason;
	logic [pbr_pkg::BURST_W-1:0]        local_beats_remaining;
	logic                               wide_transfer_flag_n;
	logic                               low_half_strobe_n;
	logic                               high_half_strobe_n;
	logic [pbr_pkg::DATA_W-1:0]         local_data_out;

	modport bridge (
		input  local_wide_request_n,
		input  local_start_addr,
		input  local_cmd_byte_enable_input,
		input  local_cmd,
		input  local_burst_size,
		input  local_ready_n,
		output local_grant_n,
		output local_transfer_state,
		output local_end_reason,
		output local_beats_remaining,
		output wide_transfer_flag_n,
		output low_half_strobe_n,
		output high_half_strobe_n,
		output local_data_out
	);

	modport user (
		output local_wide_request_n,
		output local_start_addr,
		output local_cmd_byte_enable_input,
		output local_cmd,
		output local_burst_size,
		output local_ready_n,
		input  local_grant_n,
		input  local_transfer_state,
		input  local_end_reason,
		input  local_beats_remaining,
		input  wide_transfer_flag_n,
		input  low_half_strobe_n,
		input  high_half_strobe_n,
		input  local_data_out
	);
endinterface

// file: hdl/pbr_local_user.sv
`timescale 1ns/1ps

module pbr_local_user (
	// Clock and reset
	input  wire logic                         core_clk,
	input  wire logic                         rst,
	// Bridge side
	pbr_local_if.user                         lu,
	// Command port
	input  wire logic                         cmd_valid,
	output      logic                         cmd_ready,
	input  wire logic [pbr_pkg::HALF_W-1:0]   cmd_addr,
	input  wire logic [pbr_pkg::CMD_W-1:0]    cmd_code,
	input  wire logic [pbr_pkg::BURST_W-1:0]  cmd_burst,
	input  wire logic [pbr_pkg::BE_W-1:0]     cmd_be,
	// Read data port
	output      logic                         rd_valid,
	input  wire logic                         rd_ready,
	output      logic [pbr_pkg::DATA_W-1:0]   rd_data,
	output      logic [pbr_pkg::HALF_W-1:0]   next_addr
);

	// ----------------------------------------------------------------
	// Request side
	// ----------------------------------------------------------------
	logic                           req_n_ff;
	logic [pbr_pkg::HALF_W-1:0]     addr_ff;
	logic [pbr_pkg::CMD_W-1:0]      code_ff;
	logic [pbr_pkg::BURST_W-1:0]    burst_ff;
	logic [pbr_pkg::BE_W-1:0]       be_ff;

	assign cmd_ready = req_n_ff && (lu.local_transfer_state != pbr_pkg::ST_BUS_TRANS);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			req_n_ff <= 1'b1;
			code_ff  <= pbr_pkg::CMD_RST;
			burst_ff <= pbr_pkg::BEATS_ZERO;
			be_ff    <= pbr_pkg::BE_RST;
		end else if (cmd_valid && cmd_ready) begin
			req_n_ff <= 1'b0;                                              // [R4]
			code_ff  <= cmd_code;
			burst_ff <= cmd_burst;
			be_ff    <= cmd_be;                                            // [R11]
		end else if (lu.local_transfer_state == pbr_pkg::ST_ADDR_LOAD) begin
			req_n_ff <= 1'b1;                                              // [R8]
		end
	end

	// Address counter doubles as start address while requesting
	always_ff @(posedge core_clk) begin
		if (rst) begin
			addr_ff <= pbr_pkg::ADDR_RST;
		end else if (cmd_valid && cmd_ready) begin
			addr_ff <= cmd_addr;
		end else if (!lu.low_half_strobe_n || !lu.high_half_strobe_n) begin
			addr_ff <= addr_ff + pbr_pkg::DWORD_STEP;                      // [R18]
		end
	end

	// ----------------------------------------------------------------
	// Two-entry buffer for read QWORDs
	// ----------------------------------------------------------------
	// Ready drops while full, so the bridge never strobes a word we cannot keep
	logic [pbr_pkg::DATA_W-1:0]  mem_ff [pbr_pkg::FIFO_DEPTH];
	logic [pbr_pkg::HALF_W-1:0]  low_ff;
	logic                        wr_ptr_ff;
	logic                        rd_ptr_ff;
	logic [1:0]                  count_ff;
	logic                        push;
	logic                        pop;
	logic                        full;

	assign full     = (count_ff == 2'(pbr_pkg::FIFO_DEPTH));
	assign push     = !lu.high_half_strobe_n && !full;
	assign pop      = rd_valid && rd_ready;
	assign rd_valid = (count_ff != 2'h0);
	assign rd_data  = mem_ff[rd_ptr_ff];

	always_ff @(posedge core_clk) begin
		if (rst) begin
			low_ff <= pbr_pkg::ADDR_RST;
		end else if (!lu.low_half_strobe_n) begin
			low_ff <= lu.local_data_out[31:0];                             // [R18]
		end
	end

	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= {lu.local_data_out[63:32], low_ff};
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			wr_ptr_ff <= 1'b0;
			rd_ptr_ff <= 1'b0;
			count_ff  <= 2'h0;
		end else begin
			if (push) begin
				wr_ptr_ff <= !wr_ptr_ff;
			end
			if (pop) begin
				rd_ptr_ff <= !rd_ptr_ff;
			end
			if (push && !pop) begin
				count_ff <= count_ff + 2'h1;
			end else if (pop && !push) begin
				count_ff <= count_ff - 2'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign lu.local_wide_request_n        = req_n_ff;
	assign lu.local_start_addr            = addr_ff;
	assign lu.local_cmd                   = code_ff;
	assign lu.local_burst_size            = burst_ff;
	assign lu.local_cmd_byte_enable_input = be_ff;
	assign lu.local_ready_n               = full;                         // [R11]
	assign next_addr                      = addr_ff;

endmodule

// file: verification/pbr_checker_sva.sv
`timescale 1ns/1ps
module pbr_checker_sva (
	// Clock and reset
	input wire logic       core_clk,
	input wire logic       rst,
	// Local side
	input wire logic       local_wide_request_n,
	input wire logic       local_grant_n,
	input wire logic [3:0] local_transfer_state,
	input wire logic [1:0] local_end_reason,
	input wire logic [7:0] local_beats_remaining,
	input wire logic [7:0] local_burst_size,
	input wire logic       local_ready_n,
	input wire logic       low_half_strobe_n,
	// PCI side
	input wire logic       reqn,
	input wire logic       gntn,
	input wire logic       framen_out,
	input wire logic       framen_oe,
	input wire logic       irdyn_out,
	input wire logic       trdyn
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	wire done = !irdyn_out && !trdyn;
	chk_reqn_raise: assert property ($fell(local_wide_request_n) |=> !reqn)
		else $error("bus request not raised");
	chk_load_state: assert property (!local_wide_request_n && !local_grant_n &&
		local_transfer_state == pbr_pkg::ST_IDLE |=> local_transfer_state == pbr_pkg::ST_ADDR_LOAD)
		else $error("no address loading after grant");
	chk_addr_phase: assert property (local_transfer_state == pbr_pkg::ST_ADDR_LOAD && !gntn
		|=> local_transfer_state == pbr_pkg::ST_BUS_TRANS && !framen_out && framen_oe)
		else $error("address phase missing");
	chk_beats_load: assert property (local_transfer_state == pbr_pkg::ST_ADDR_LOAD
		|=> local_beats_remaining == $past(local_burst_size))
		else $error("burst counter not loaded");
	chk_frame_last: assert property (done && !framen_out && !local_ready_n &&
		local_beats_remaining == pbr_pkg::BEATS_SPLIT |=> framen_out && !irdyn_out)
		else $error("last phase framing wrong");
	chk_low_strobe: assert property ($fell(low_half_strobe_n)
		|-> $past(done && !local_ready_n) ##1 low_half_strobe_n)
		else $error("low strobe out of place");
	chk_term_status: assert property (done && framen_out &&
		local_transfer_state == pbr_pkg::ST_BUS_TRANS |=> irdyn_out &&
		local_transfer_state == pbr_pkg::ST_BUS_TERM && local_end_reason == pbr_pkg::END_NORMAL)
		else $error("termination not reported");
	chk_reqn_drop: assert property (!framen_out && framen_oe && local_wide_request_n |=> reqn)
		else $error("bus request held too long");
	chk_grant_follow: assert property ($rose(gntn) |=> local_grant_n)
		else $error("local grant kept after bus grant went");
	chk_state_code: assert property (local_transfer_state <= pbr_pkg::ST_BUS_TERM)
		else $error("unknown status code");
	cover property (local_transfer_state == pbr_pkg::ST_BUS_TERM);
	cover property ($fell(low_half_strobe_n));
	cover property (local_ready_n && local_transfer_state == pbr_pkg::ST_BUS_TRANS);
endmodule

// file: verification/pci32_master_local64_read_tb.sv
`timescale 1ns/1ps
module pci32_master_local64_read_tb;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic        gntn = 1'b1;
	logic        trdyn = 1'b1;
	logic        devseln = 1'b1;
	logic        cmd_valid = 1'b0;
	logic        rd_ready = 1'b0;
	logic [31:0] cmd_addr = 32'h0000_0000;
	logic [31:0] ad_in = 32'h0000_0000;
	logic [7:0]  cmd_be = 8'h00;
	logic        reqn, framen_out, framen_oe, irdyn_out, irdyn_oe, ad_oe, cben_oe;
	logic        cmd_ready, rd_valid;
	logic [31:0] ad_out;
	logic [3:0]  cben_out;
	logic [63:0] rd_data;
	int          errors = 0;
	int          total_checks = 0;
	pbr_local_if bif ();
	always #2 core_clk = ~core_clk;
	// Released control pins float to their pull-up level
	pbr_bridge u_pbr_bridge (.core_clk, .rst, .lb(bif), .reqn, .gntn,
		.framen_in(framen_oe ? framen_out : 1'b1), .framen_out, .framen_oe,
		.irdyn_in(irdyn_oe ? irdyn_out : 1'b1), .irdyn_out, .irdyn_oe, .req64n_out(),
		.req64n_oe(), .ad_in, .ad_out, .ad_oe, .cben_out, .cben_oe, .trdyn, .devseln,
		.ack64n(1'b1));
	pbr_local_user u_pbr_local_user (.core_clk, .rst, .lu(bif), .cmd_valid, .cmd_ready,
		.cmd_addr, .cmd_code(4'h6), .cmd_burst(8'h01), .cmd_be, .rd_valid, .rd_ready,
		.rd_data, .next_addr());
	pbr_checker_sva u_pbr_checker_sva (.core_clk, .rst, .reqn, .gntn, .framen_out,
		.framen_oe, .irdyn_out, .trdyn, .local_ready_n(bif.local_ready_n),
		.local_wide_request_n(bif.local_wide_request_n), .local_grant_n(bif.local_grant_n),
		.local_transfer_state(bif.local_transfer_state),
		.local_end_reason(bif.local_end_reason), .local_burst_size(bif.local_burst_size),
		.local_beats_remaining(bif.local_beats_remaining),
		.low_half_strobe_n(bif.low_half_strobe_n));
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Target answers as a 32-bit device, never claiming the wide transfer
	task automatic run_read(input logic [31:0] addr, lo, hi, input logic [7:0] be);
		int k = 0;
		int n = 0;
		@(negedge core_clk);
		cmd_valid = 1'b1;
		cmd_addr = addr;
		cmd_be = be;
		@(negedge core_clk);
		cmd_valid = 1'b0;
		for (int i = 0; i < 50 && reqn; i++) @(negedge core_clk);
		gntn = 1'b0;
		for (int i = 0; i < 50 && !(framen_oe && !framen_out); i++) @(negedge core_clk);
		chk("address", {32'h0000_0000, addr}, {32'h0000_0000, ad_out});
		chk("command", 64'h0000_0000_0000_0006, {60'h0, cben_out});
		gntn = 1'b1;
		devseln = 1'b0;
		@(negedge core_clk);
		chk("ad enable", 64'h0000_0000_0000_0000, {63'h0, ad_oe});
		@(negedge core_clk);
		trdyn = 1'b0;
		while (n < 2 && k < 100) begin
			ad_in = n ? hi : lo;
			if (!irdyn_out) begin
				if (!n) chk("enables", {60'h0, addr[2] ? be[7:4] : be[3:0]}, {60'h0, cben_out});
				n++;
			end
			@(negedge core_clk);
			k++;
		end
		trdyn = 1'b1;
		devseln = 1'b1;
		ad_in = ~ad_in;
		repeat (3) @(negedge core_clk);
		chk("end reason", {62'h0, pbr_pkg::END_NORMAL}, {62'h0, bif.local_end_reason});
		chk("wide flag", 64'h0000_0000_0000_0001, {63'h0, bif.wide_transfer_flag_n});
		chk("status", {60'h0, pbr_pkg::ST_IDLE}, {60'h0, bif.local_transfer_state});
	endtask
	task automatic pop(input logic [63:0] exp, input logic [63:0] mask);
		for (int i = 0; i < 200 && !rd_valid; i++) @(negedge core_clk);
		chk("read word", exp & mask, rd_data & mask);
		rd_ready = 1'b1;
		@(negedge core_clk);
		rd_ready = 1'b0;
		@(negedge core_clk);
	endtask
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(negedge core_clk);
		rst = 1'b0;
		run_read(32'h0000_1000, 32'h1111_2222, 32'h3333_4444, 8'hf0);
		run_read(32'h0000_1008, 32'h5555_6666, 32'h7777_8888, 8'h0f);
		chk("ready when full", 64'h0000_0000_0000_0001, {63'h0, bif.local_ready_n});
		$display("test fill done");
		fork
			run_read(32'h0000_1010, 32'h9999_aaaa, 32'hbbbb_cccc, 8'h00);
			begin
				repeat (20) @(negedge core_clk);
				pop(64'h3333_4444_1111_2222, 64'hffff_ffff_ffff_ffff);
				pop(64'h7777_8888_5555_6666, 64'hffff_ffff_ffff_ffff);
			end
		join
		pop(64'hbbbb_cccc_9999_aaaa, 64'hffff_ffff_ffff_ffff);
		$display("test stall done");
		run_read(32'h0000_2004, 32'hdddd_eeee, 32'h0123_4567, 8'h3c);
		pop(64'hdddd_eeee_0000_0000, 64'hffff_ffff_0000_0000);
		$display("test unaligned done");
		give_verdict();
	end
	initial begin
		#20000;
		errors++;
		give_verdict();
	end
endmodule
